// *** esm_field_model.sv ***
`timescale 1ns/1ps
// Guided-contact relays: the NC contacts sit in the feedback loop
module esm_field_model (
    input  wire logic hclk,
    input  wire logic out_a,
    input  wire logic out_b,
    input  wire logic fault,
    output logic      relay_feedback_loop
);
    initial relay_feedback_loop = 1'b1;
    // One cycle of contact travel; a fault condition breaks the loop
    always @(posedge hclk) begin
        relay_feedback_loop <= !(out_a || out_b) && !fault;
    end
endmodule : esm_field_model

// *** esm_monitor.sv ***
// The AHB-Lite interface to the registers and the register offsets are this design's own decisions.
`timescale 1ns/1ps
// Operation
// RL1 - Any actuated stop contact or loss of external supply opens every safety output at once.
// RL2 - One open channel is enough to open the outputs, without waiting for its companion.
// RL3 - Outputs reclose only with the feedback loop closed together with a reactivation request.
// RL4 - After the inputs are restored, outputs close only after a reactivation pulse.
// RL5 - With the monitoring strap open, outputs close on the falling edge of reactivation.
// RL6 - With the monitoring strap closed, outputs close on the reactivation level.
// RL7 - Both strap and reactivation shunted gives automatic start once both channels close.
// RL8 - In automatic start, channel closures more than 1 s apart inhibit activation.
// RL9 - Reactivation is allowed only after both channels have been seen open.
// RL10 - Selector on the first positive terminal means double contacts, two channels.
// RL11 - Selector on the last positive terminal means single contacts, negative shunted.
// RL12 - Only diagnostics go to the CPU; the CPU has no path to the outputs.
// RL13 - Outputs are removed independently of the CPU, even with it absent.
// RL14 - The outside controller may add a fault condition into the feedback loop.
// RL15 - Inputs, reactivation, feedback, output control and supply form a 28-bit status.
// RL16 - After power-up, outputs stay open until a full valid reactivation sequence.
module esm_monitor (
    input  wire logic                       hclk,
    input  wire logic                       hresetn,
    input  wire logic                       hsel,
    input  wire logic [31:0]                haddr,
    input  wire logic [1:0]                 htrans,
    input  wire logic                       hwrite,
    input  wire logic [2:0]                 hsize,
    input  wire logic [31:0]                hwdata,
    input  wire logic                       hready,
    output logic      [31:0]                hrdata,
    output logic                            hreadyout,
    output logic                            hresp,
    input  wire logic [esm_pkg::NUM_CH-1:0] pos_contact,
    input  wire logic [esm_pkg::NUM_CH-1:0] neg_contact,
    input  wire logic                       contact_type_select,
    input  wire logic                       reactivation_input,
    input  wire logic                       reactivation_monitor_strap,
    input  wire logic                       relay_feedback_loop,
    input  wire logic                       external_supply_ok,
    output logic                            safety_output_circuit_a,
    output logic                            safety_output_circuit_b,
    output logic                            irq
);
    localparam int unsigned PW = 2 * esm_pkg::NUM_CH + 5;

    logic [PW-1:0]                  pins_s;
    logic [esm_pkg::NUM_CH-1:0]     pos_s;
    logic [esm_pkg::NUM_CH-1:0]     neg_s;
    logic                           dbl_s;
    logic                           react_s;
    logic                           strap_s;
    logic                           fbk_s;
    logic                           supply_s;
    logic                           react_d;
    logic                           pos_closed;
    logic                           neg_closed;
    logic                           any_open;
    logic                           both_open;
    logic                           auto_mode;
    logic                           request;
    esm_pkg::esm_state_t            state;
    logic                           pos_seen;
    logic                           neg_seen;
    logic [esm_pkg::CNT_W-1:0]      skew_cnt;
    logic                           skew_run;
    logic                           skew_bad;
    logic                           out_on;
    logic [esm_pkg::STAT_W-1:0]     status;
    logic [esm_pkg::STAT_W-1:0]     mask;
    logic [esm_pkg::STAT_W-1:0]     event_set;
    logic [esm_pkg::DIAG_W-1:0]     diag;
    logic                           ph_valid;
    logic                           ph_write;
    logic [7:0]                     ph_addr;
    logic                           rd_status;
    logic                           wr_mask;
    logic                           skew_clear;
    logic [1:0]                     sync_fill;

    // Data-phase hit on one register; the read clear and the mask write both use it
    function automatic logic reg_hit(
        input logic       valid,
        input logic       write,
        input logic [7:0] addr,
        input logic       want_write,
        input logic [7:0] want_addr
    );
        return valid && (write == want_write) && (addr == want_addr);
    endfunction : reg_hit

    // Shared by the seen-flag clear, the outputs and the trip event
    function automatic logic is_closed(
        input esm_pkg::esm_state_t s
    );
        return s == esm_pkg::ESM_CLOSED;
    endfunction : is_closed

    // Every pin level is synchronised before any logic reads it
    esm_sync #(.W(PW)) u_sync (
        .hclk    (hclk),
        .hresetn (hresetn),
        .d       ({external_supply_ok, relay_feedback_loop, reactivation_monitor_strap,
                   reactivation_input, contact_type_select, neg_contact, pos_contact}),
        .q       (pins_s)
    );

    assign pos_s    = pins_s[esm_pkg::NUM_CH-1:0];
    assign dbl_s    = pins_s[2*esm_pkg::NUM_CH];
    assign react_s  = pins_s[2*esm_pkg::NUM_CH+1];
    assign strap_s  = pins_s[2*esm_pkg::NUM_CH+2];
    assign fbk_s    = pins_s[2*esm_pkg::NUM_CH+3];
    assign supply_s = pins_s[2*esm_pkg::NUM_CH+4];

    // Single contacts: negative channel is globally shunted, so it reads closed
    assign neg_s = dbl_s ? pins_s[2*esm_pkg::NUM_CH-1:esm_pkg::NUM_CH]
                         : {esm_pkg::NUM_CH{1'b1}}; // RL10 RL11

    assign pos_closed = &pos_s;
    assign neg_closed = &neg_s;
    assign any_open   = !pos_closed || !neg_closed || !supply_s; // RL1 RL2
    // Single contacts leave only the positive channel to be seen open
    assign both_open  = pos_seen && (neg_seen || !dbl_s); // RL9 RL11
    assign auto_mode  = strap_s && react_s; // RL7

    // Edge or level start; automatic start needs no pulse but keeps the skew check
    always_comb begin
        if (auto_mode) begin
            request = !skew_bad; // RL7 RL8
        end else if (strap_s) begin
            request = react_s; // RL6
        end else begin
            request = react_d && !react_s; // RL5
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            react_d <= 1'b0;
        end else begin
            react_d <= react_s;
        end
    end

    // The synchroniser resets to all-open, which would pass for a press of every
    // stop; its levels are trusted only once real pin samples reach its second
    // stage, so a reset never counts as the channels having been seen open
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sync_fill <= '0;
        end else begin
            sync_fill <= {sync_fill[0], 1'b1};
        end
    end

    // Each channel must be seen open since the last activation
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pos_seen <= 1'b0;
            neg_seen <= 1'b0;
        end else if (is_closed(state) && !any_open) begin
            pos_seen <= 1'b0;
            neg_seen <= 1'b0;
        end else begin
            if (sync_fill[1] && !pos_closed) begin
                pos_seen <= 1'b1; // RL9 RL16
            end
            if (sync_fill[1] && !neg_closed) begin
                neg_seen <= 1'b1; // RL9
            end
        end
    end

    // Single contacts have no second channel to lag, so an open positive channel
    // restarts the timer; otherwise a long stop would inhibit automatic start for good
    assign skew_clear = !pos_closed && (!neg_closed || !dbl_s);

    // Skew timer from the first channel closing to the second
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            skew_cnt <= '0;
            skew_run <= 1'b0;
            skew_bad <= 1'b0;
        end else if (skew_clear) begin
            skew_cnt <= '0;
            skew_run <= 1'b0;
            skew_bad <= 1'b0;
        end else if (pos_closed && neg_closed) begin
            skew_run <= 1'b0;
        end else begin
            skew_run <= 1'b1;
            if (skew_cnt < esm_pkg::CNT_W'(esm_pkg::INHIBIT_CYC)) begin
                skew_cnt <= skew_cnt + 1'b1;
            end else begin
                skew_bad <= 1'b1; // RL8
            end
        end
    end

    // Safety state machine; no bus signal reaches it
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state <= esm_pkg::ESM_OPEN; // RL16
        end else begin
            case (state)
                esm_pkg::ESM_OPEN: begin
                    if (both_open && !any_open) begin
                        state <= esm_pkg::ESM_ARMED;
                    end
                end
                esm_pkg::ESM_ARMED: begin
                    if (any_open) begin
                        state <= esm_pkg::ESM_OPEN; // RL2
                    end else if (fbk_s && request) begin
                        state <= esm_pkg::ESM_CLOSED; // RL3 RL4 RL14
                    end
                end
                esm_pkg::ESM_CLOSED: begin
                    if (any_open) begin
                        state <= esm_pkg::ESM_OPEN; // RL1
                    end
                end
                default: state <= esm_pkg::ESM_OPEN;
            endcase
        end
    end

    // Combinational drop keeps the trip path free of a register delay
    assign out_on = is_closed(state) && !any_open; // RL1 RL13
    assign safety_output_circuit_a = out_on;
    assign safety_output_circuit_b = out_on;

    assign diag = {supply_s, out_on, fbk_s, react_s, neg_s, pos_s}; // RL15

    assign event_set[esm_pkg::EV_TRIP] = is_closed(state) && any_open;
    assign event_set[esm_pkg::EV_ARM]  = (state == esm_pkg::ESM_OPEN) && both_open && !any_open;
    assign event_set[esm_pkg::EV_ON]   = (state == esm_pkg::ESM_ARMED) && !any_open
                                         && fbk_s && request;
    assign event_set[esm_pkg::EV_SKEW] = skew_run && !skew_bad
                                         && skew_cnt == esm_pkg::CNT_W'(esm_pkg::INHIBIT_CYC);

    // AHB-Lite slave, zero wait states, always OKAY
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ph_valid <= 1'b0;
            ph_write <= 1'b0;
            ph_addr  <= '0;
        end else if (hready) begin
            ph_valid <= hsel && htrans[1];
            ph_write <= hwrite;
            ph_addr  <= haddr[7:0];
        end
    end

    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    // Strobes for the data phase, one cycle after the address was taken
    assign rd_status = reg_hit(ph_valid, ph_write, ph_addr, 1'b0, esm_pkg::ADDR_STATUS);
    assign wr_mask   = reg_hit(ph_valid, ph_write, ph_addr, 1'b1, esm_pkg::ADDR_MASK);

    // Only the mask is writable; the outputs have no software path
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            mask <= '0;
        end else if (wr_mask) begin
            mask <= hwdata[esm_pkg::STAT_W-1:0]; // RL12
        end
    end

    // Clear only the bits that the read returned, so an event arriving between
    // the address and data phases is not lost; a new set still wins
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            status <= '0;
        end else if (rd_status) begin
            status <= (status & ~hrdata[esm_pkg::STAT_W-1:0]) | event_set;
        end else begin
            status <= status | event_set;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq <= 1'b0;
        end else begin
            irq <= |(status & mask);
        end
    end

    // Read data is sampled at the address phase so it stands in the data phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= esm_pkg::RESET_WORD;
        end else if (hready && hsel && htrans[1] && !hwrite) begin
            case (haddr[7:0])
                esm_pkg::ADDR_DIAG:   hrdata <= {4'h0, diag}; // RL15
                esm_pkg::ADDR_STATUS: hrdata <= {28'h0, status};
                esm_pkg::ADDR_MASK:   hrdata <= {28'h0, mask};
                esm_pkg::ADDR_STATE:  hrdata <= {27'h0, skew_bad, out_on, 1'b0, state};
                default:              hrdata <= esm_pkg::RESET_WORD;
            endcase
        end
    end
endmodule : esm_monitor

// *** esm_monitor_sva.sv ***
`timescale 1ns/1ps
module esm_monitor_chk (
    input wire logic                       hclk,
    input wire logic                       hresetn,
    input wire logic                       hreadyout,
    input wire logic                       hresp,
    input wire logic [esm_pkg::NUM_CH-1:0] pos_contact,
    input wire logic [esm_pkg::NUM_CH-1:0] neg_contact,
    input wire logic                       contact_type_select,
    input wire logic                       reactivation_input,
    input wire logic                       reactivation_monitor_strap,
    input wire logic                       relay_feedback_loop,
    input wire logic                       external_supply_ok,
    input wire logic                       safety_output_circuit_a,
    input wire logic                       safety_output_circuit_b
);
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    outputs_equal_a: assert property (safety_output_circuit_a == safety_output_circuit_b)
        else $error("safety outputs differ");
    supply_trip_a: assert property (!external_supply_ok [*4] |-> !safety_output_circuit_a)
        else $error("output closed without supply");
    pos_trip_a: assert property ((pos_contact != '1) [*4] |-> !safety_output_circuit_a)
        else $error("output closed with a positive channel open");
    neg_trip_a: assert property
        ((contact_type_select && neg_contact != '1) [*4] |-> !safety_output_circuit_a)
        else $error("output closed with a negative channel open");
    fbk_needed_a: assert property
        ($rose(safety_output_circuit_a) |-> $past(relay_feedback_loop, 3))
        else $error("output closed with feedback loop open");
    edge_start_a: assert property
        ($rose(safety_output_circuit_a) && !$past(reactivation_monitor_strap, 3)
            |-> !$past(reactivation_input, 3))
        else $error("edge mode closed while request held");
    level_start_a: assert property
        ($rose(safety_output_circuit_a) && $past(reactivation_monitor_strap, 3)
            |-> $past(reactivation_input, 3))
        else $error("level mode closed without request");
    bus_okay_a: assert property (hreadyout && !hresp)
        else $error("bus response not ready and okay");
endmodule : esm_monitor_chk

bind esm_monitor esm_monitor_chk chk (.hclk(hclk), .hresetn(hresetn), .hreadyout(hreadyout),
    .hresp(hresp), .pos_contact(pos_contact), .neg_contact(neg_contact),
    .contact_type_select(contact_type_select), .reactivation_input(reactivation_input),
    .reactivation_monitor_strap(reactivation_monitor_strap),
    .relay_feedback_loop(relay_feedback_loop), .external_supply_ok(external_supply_ok),
    .safety_output_circuit_a(safety_output_circuit_a),
    .safety_output_circuit_b(safety_output_circuit_b));

// *** esm_pkg.sv ***
package esm_pkg;
    localparam int unsigned CLK_HZ        = 40_000_000;
    localparam int unsigned SKEW_MS       = 400;
    localparam int unsigned INHIBIT_MS    = 1000;
    localparam int unsigned SKEW_CYCLES   = (CLK_HZ / 1000) * SKEW_MS;
    localparam int unsigned INHIBIT_CYC   = (CLK_HZ / 1000) * INHIBIT_MS;
    localparam int unsigned NUM_CH        = 12;
    localparam int unsigned DIAG_W        = 28;
    localparam int unsigned CNT_W         = 26;
    localparam int unsigned STAT_W        = 4;

    // Register byte addresses
    localparam logic [7:0] ADDR_DIAG   = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h04;
    localparam logic [7:0] ADDR_MASK   = 8'h08;
    localparam logic [7:0] ADDR_STATE  = 8'h0c;

    // Sticky event bits
    localparam int unsigned EV_TRIP    = 0;
    localparam int unsigned EV_ARM     = 1;
    localparam int unsigned EV_ON      = 2;
    localparam int unsigned EV_SKEW    = 3;

    // Diagnostic word fields
    localparam int unsigned DG_POS     = 0;
    localparam int unsigned DG_NEG     = 12;
    localparam int unsigned DG_REACT   = 24;
    localparam int unsigned DG_FBK     = 25;
    localparam int unsigned DG_OUT     = 26;
    localparam int unsigned DG_SUPPLY  = 27;

    localparam logic [31:0] RESET_WORD = 32'h0000_0000;

    typedef enum logic [1:0] {
        ESM_OPEN,
        ESM_ARMED,
        ESM_CLOSED
    } esm_state_t;
endpackage : esm_pkg

// *** esm_sync.sv ***
`timescale 1ns/1ps
// Two-flop synchroniser for a bundle of pin levels
module esm_sync #(
    parameter int unsigned W = 1
) (
    input  wire logic         hclk,
    input  wire logic         hresetn,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] meta;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            meta <= '0;
            q    <= '0;
        end else begin
            meta <= d;
            q    <= meta;
        end
    end
endmodule : esm_sync

// *** testbench.sv ***
`timescale 1ns/1ps
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin fails++; \
    $display("[ERR] %0t got %h expected %h", $time, g, e); end end
module testbench;
    typedef struct {logic strap; logic hold; logic fault; logic exp;} esm_row_t;
    logic        hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, fault = 0, sel = 1;
    logic        react = 0, strap = 0, supply = 1;
    logic [31:0] haddr = '0, hwdata = '0, hrdata, rd;
    logic [1:0]  htrans = '0;
    logic [2:0]  hsize = 3'h2;
    logic [11:0] pos = 12'hfff, neg = 12'hfff;
    wire         hreadyout, hresp, out_a, out_b, irq, fbk;
    int          fails = 0, check_count = 0, cyc = 0;
    esm_row_t    rows [4] = '{'{0, 0, 0, 1}, '{1, 0, 0, 1}, '{1, 1, 0, 1}, '{0, 0, 1, 0}};
    esm_monitor dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .pos_contact(pos), .neg_contact(neg), .contact_type_select(sel),
        .reactivation_input(react), .reactivation_monitor_strap(strap),
        .relay_feedback_loop(fbk), .external_supply_ok(supply),
        .safety_output_circuit_a(out_a), .safety_output_circuit_b(out_b), .irq(irq));
    esm_field_model field (.hclk(hclk), .out_a(out_a), .out_b(out_b), .fault(fault),
        .relay_feedback_loop(fbk));
    always #12.5 hclk = ~hclk;
    task automatic finish_test();
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : finish_test
    always @(posedge hclk) begin
        cyc++;
        if (cyc == 5000) begin
            fails++;
            finish_test();
        end
    end
    task automatic wait_n(int n);
        repeat (n) @(posedge hclk);
    endtask : wait_n
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge hclk);
        hsel <= 1; htrans <= 2'b10; hwrite <= w; haddr <= {24'h0, a};
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        hsel <= 0; htrans <= 2'b00; hwdata <= d;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        rd = hrdata;
    endtask : bus
    task automatic pulse();
        react <= 1;
        wait_n(6);
        react <= 0;
        wait_n(8);
    endtask : pulse
    // Every channel seen open, then all closed together, so no skew
    task automatic run_row(esm_row_t r);
        @(posedge hclk);
        strap <= r.strap; fault <= r.fault; pos <= '0; neg <= '0; react <= r.hold;
        wait_n(6);
        pos <= '1; neg <= '1;
        wait_n(6);
        if (!r.hold) begin
            react <= 1;
            wait_n(6);
            if (!r.strap) begin
                `CHK(out_a, 1'b0)
                react <= 0;
                wait_n(6);
            end
        end
        `CHK(out_a, r.exp)
        react <= 0; strap <= 0; fault <= 0;
        $display("row strap %b hold %b fault %b done", r.strap, r.hold, r.fault);
    endtask : run_row
    initial begin
        wait_n(10);
        hresetn <= 1;
        wait_n(1);
        `CHK({out_a, out_b, irq, hrdata}, 35'h0)
        pulse(); // Channels never opened since power-up
        `CHK(out_a, 1'b0)
        $display("reset test done");
        foreach (rows[i]) run_row(rows[i]);
        run_row(rows[0]);
        pos[5] <= 0;
        wait_n(4);
        `CHK(out_a, 1'b0)
        pos[5] <= 1;
        wait_n(4);
        pulse(); // Negative channels were never seen open
        `CHK(out_a, 1'b0)
        run_row(rows[0]);
        supply <= 0;
        wait_n(4);
        `CHK({out_a, out_b}, 2'b00)
        supply <= 1;
        $display("trip tests done");
        @(posedge hclk);
        strap <= 1; react <= 1; pos <= '0; neg <= '0;
        wait_n(6);
        pos <= '1;
        wait_n(20);
        `CHK(out_a, 1'b0)
        neg <= '1; // Second channel closes well inside the tolerated skew
        wait_n(6);
        `CHK(out_a, 1'b1)
        react <= 0; strap <= 0;
        $display("skew test done");
        @(posedge hclk);
        sel <= 0; pos <= '0; neg <= '0;
        wait_n(6);
        pos <= '1;
        wait_n(6);
        pulse();
        `CHK(out_a, 1'b1)
        bus(0, esm_pkg::ADDR_DIAG, '0);
        `CHK(rd, 32'h0cff_ffff)
        bus(1, esm_pkg::ADDR_STATE, '0);
        bus(1, esm_pkg::ADDR_DIAG, '0);
        `CHK(out_a, 1'b1)
        bus(1, esm_pkg::ADDR_MASK, 32'hf);
        bus(0, esm_pkg::ADDR_MASK, '0);
        `CHK(rd[3:0], 4'hf)
        `CHK(irq, 1'b1)
        bus(0, esm_pkg::ADDR_STATUS, '0);
        `CHK(rd[2:0], 3'b111)
        wait_n(3);
        `CHK(irq, 1'b0)
        bus(0, 8'h10, '0);
        `CHK(rd, 32'h0)
        $display("bus tests done");
        hresetn <= 0;
        wait_n(2);
        `CHK({out_a, out_b}, 2'b00)
        hresetn <= 1;
        wait_n(2);
        pulse(); // Inputs stayed closed across the reset
        `CHK(out_a, 1'b0)
        $display("mid-run reset test done");
        finish_test();
    end
endmodule : testbench
